// ==== common/tba_pkg.sv ====
// constants and types shared by the transmit-buffer arbiter files
`default_nettype none
package tba_pkg;
  localparam int TBA_NUM_BUF = 4;
  localparam int TBA_BUF_W = 2;
  localparam int TBA_ADDR_W = 5;
  localparam int TBA_TS_W = 64;
  localparam int TBA_FIFO_DEPTH = 4;
  // metadata word offsets inside a frame buffer
  localparam logic [4:0] TBA_OFS_FFMT = 5'h00;
  localparam logic [4:0] TBA_OFS_IDENT = 5'h01;
  localparam logic [4:0] TBA_OFS_TS_LO = 5'h02;
  localparam logic [4:0] TBA_OFS_TS_HI = 5'h03;
  localparam logic [4:0] TBA_OFS_DATA0 = 5'h04;
  // validation length in system clock cycles
  localparam int TBA_VALID_CYCLES = 6;
  localparam logic [31:0] TBA_META_RST = 32'h0000_0000;
  localparam logic [31:0] TBA_ID_RST = 32'h0000_0000;
  localparam logic [1:0] TBA_SEL_RST = 2'h0;

  typedef enum logic [2:0] {
    TBA_ST_IDLE = 3'b000,
    TBA_ST_TS_LO = 3'b001,
    TBA_ST_TS_HI = 3'b010,
    TBA_ST_FFMT = 3'b011,
    TBA_ST_IDENT = 3'b100,
    TBA_ST_WAIT_TS = 3'b101,
    TBA_ST_DONE = 3'b110,
    TBA_ST_LOCKED = 3'b111
  } tba_state_e;
endpackage : tba_pkg
`default_nettype wire

// ==== hdl/tba_prio_sel.sv ====
// priority decoder over available frame buffers
`default_nettype none
module tba_prio_sel
  import tba_pkg::*;
#(
  parameter int NUM_BUF = TBA_NUM_BUF,
  parameter int PRIO_W = 3
) (
  input wire logic [NUM_BUF-1:0] avail, // buffer ready for transmit
  input wire logic [NUM_BUF*PRIO_W-1:0] prio, // priority per buffer
  output logic sel_valid, // some buffer available
  output logic [TBA_BUF_W-1:0] sel_idx // highest priority index
);
  always_comb begin
    logic [PRIO_W-1:0] best;
    best = '0;
    sel_valid = 1'b0;
    sel_idx = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      // strictly higher wins, lower index wins ties
      if (avail[i] && (!sel_valid || prio[i*PRIO_W +: PRIO_W] > best)) begin
        sel_valid = 1'b1;
        sel_idx = TBA_BUF_W'(i);
        best = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end
endmodule : tba_prio_sel
`default_nettype wire

// ==== hdl/tba_fifo.sv ====
// small valid/ready fifo for transmit data words
`default_nettype none
module tba_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic in_valid, // write word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // reader takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_reg];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tba_fifo
`default_nettype wire

// ==== hdl/tba_arbiter.sv ====
// transmit frame buffer arbiter with validation and lock handling
`default_nettype none
module tba_arbiter
  import tba_pkg::*;
#(
  parameter int NUM_BUF = TBA_NUM_BUF,
  parameter int PRIO_W = 3,
  parameter int TS_W = TBA_TS_W,
  parameter bit TECH_ASIC = 1'b0 // 1 selects asic target
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic [NUM_BUF-1:0] buf_avail, // buffer ready state
  input wire logic [NUM_BUF*PRIO_W-1:0] buf_prio, // priorities
  input wire logic [NUM_BUF-1:0] buf_abort, // set abort command
  input wire logic [NUM_BUF-1:0] user_wr, // user ram write
  input wire logic [TS_W-1:0] timestamp, // time base
  output logic [TBA_ADDR_W-1:0] ram_addr, // ram port b address
  output logic [TBA_BUF_W-1:0] ram_idx, // ram port b buffer
  input wire logic [31:0] ram_rdata, // selected ram read data
  output logic [NUM_BUF-1:0] ram_clk_en, // ram clock enables
  output logic tx_validated, // validated buffer exists
  input wire logic lock_cmd, // lock from controller
  input wire logic unlock_cmd, // unlock from controller
  input wire logic [TBA_ADDR_W-1:0] ctl_addr, // data word address
  input wire logic ctl_ptr_upd, // controller read pointer moved
  output logic [31:0] tx_meta, // frame format capture
  output logic [31:0] tx_ident, // identifier capture
  output logic [TBA_BUF_W-1:0] used_idx, // used buffer index
  output logic retx_clear, // clear retransmit counter
  output logic data_valid, // data word to shift register
  input wire logic data_ready, // shift register takes word
  output logic [31:0] data_word // data word
);
  // ---------------------------------------------------------
  // selection
  // ---------------------------------------------------------
  logic sel_valid;
  logic [TBA_BUF_W-1:0] sel_idx;

  tba_prio_sel #(.NUM_BUF(NUM_BUF), .PRIO_W(PRIO_W)) u_sel (
    .avail(buf_avail),
    .prio(buf_prio),
    .sel_valid(sel_valid),
    .sel_idx(sel_idx)
  );

  // ---------------------------------------------------------
  // validation state machine
  // ---------------------------------------------------------
  tba_state_e st_reg;
  tba_state_e st_next;
  logic [TBA_BUF_W-1:0] vidx_reg;
  logic [TBA_BUF_W-1:0] vbuf_reg;
  logic vok_reg;
  logic [31:0] hold_meta_reg;
  logic [31:0] ts_lo_reg;
  logic [TS_W-1:0] frame_ts;
  logic ts_reached;
  logic restart;
  logic [TBA_BUF_W-1:0] last_used_reg;
  logic rd_pend_reg;
  logic [31:0] rd_word_reg;
  logic fifo_ready;

  assign frame_ts = TS_W'({ram_rdata, ts_lo_reg});
  assign ts_reached = (timestamp >= frame_ts);
  assign restart = !sel_valid || (sel_idx != vidx_reg);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      TBA_ST_IDLE: if (sel_valid) st_next = TBA_ST_TS_LO;
      TBA_ST_TS_LO: st_next = TBA_ST_TS_HI;
      TBA_ST_TS_HI: st_next = TBA_ST_WAIT_TS;
      TBA_ST_WAIT_TS: if (ts_reached) st_next = TBA_ST_FFMT;
      TBA_ST_FFMT: st_next = TBA_ST_IDENT;
      TBA_ST_IDENT: st_next = TBA_ST_DONE;
      TBA_ST_DONE: st_next = TBA_ST_DONE;
      TBA_ST_LOCKED: if (unlock_cmd) st_next = TBA_ST_IDLE;
      default: st_next = TBA_ST_IDLE;
    endcase
    // lock has priority over any restart or capture
    if (lock_cmd && tx_validated) begin
      st_next = TBA_ST_LOCKED;
    end else if (st_reg != TBA_ST_LOCKED && st_reg != TBA_ST_IDLE &&
                 restart) begin
      st_next = sel_valid ? TBA_ST_TS_LO : TBA_ST_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= TBA_ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vidx_reg <= TBA_SEL_RST;
    end else if (st_reg != TBA_ST_LOCKED && !(lock_cmd && tx_validated)) begin
      vidx_reg <= sel_idx;
    end
  end

  // low timestamp word held while high word is read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ts_lo_reg <= '0;
    end else if (st_reg == TBA_ST_TS_LO) begin
      ts_lo_reg <= ram_rdata;
    end
  end

  // timestamp high word is re-read each wait cycle from the ram
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_meta_reg <= TBA_META_RST;
    end else if (st_reg == TBA_ST_FFMT && !restart) begin
      hold_meta_reg <= ram_rdata;
    end
  end

  // capture both words together, never during lock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_meta <= TBA_META_RST;
      tx_ident <= TBA_ID_RST;
      vbuf_reg <= TBA_SEL_RST;
    end else if (st_reg == TBA_ST_IDENT && !restart && !lock_cmd) begin
      tx_meta <= hold_meta_reg;
      tx_ident <= ram_rdata;
      vbuf_reg <= vidx_reg;
    end
  end

  // outside the locked state, validated flag drops on a selection change or when its buffer leaves ready state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vok_reg <= 1'b0;
    end else if (st_reg == TBA_ST_LOCKED) begin
      vok_reg <= !unlock_cmd;
    end else if (lock_cmd && tx_validated) begin
      vok_reg <= 1'b1;
    end else if (st_reg == TBA_ST_IDENT && !restart) begin
      vok_reg <= 1'b1;
    end else if (restart || !buf_avail[vbuf_reg]) begin
      vok_reg <= 1'b0;
    end
  end

  // abort removes indication in the same cycle
  assign tx_validated = vok_reg && !buf_abort[vbuf_reg] &&
                        (st_reg == TBA_ST_LOCKED || buf_avail[vbuf_reg]);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      used_idx <= TBA_SEL_RST;
      last_used_reg <= TBA_SEL_RST;
    end else if (lock_cmd && tx_validated && st_reg != TBA_ST_LOCKED) begin
      used_idx <= vbuf_reg;
      last_used_reg <= vbuf_reg;
    end
  end

  // abort of last used buffer clears retransmit count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      retx_clear <= 1'b0;
    end else begin
      retx_clear <= buf_abort[last_used_reg];
    end
  end

  // ---------------------------------------------------------
  // ram addressing and clock gating
  // ---------------------------------------------------------
  logic arb_rd;

  always_comb begin
    ram_addr = TBA_OFS_TS_LO;
    ram_idx = vidx_reg;
    unique case (st_reg)
      TBA_ST_TS_HI, TBA_ST_WAIT_TS: ram_addr = TBA_OFS_TS_HI;
      TBA_ST_FFMT: ram_addr = TBA_OFS_FFMT;
      TBA_ST_IDENT: ram_addr = TBA_OFS_IDENT;
      TBA_ST_LOCKED: begin
        ram_addr = ctl_addr;
        ram_idx = used_idx;
      end
      default: ram_addr = TBA_OFS_TS_LO;
    endcase
  end

  // arbiter reads from start of validation until capture
  assign arb_rd = (st_reg != TBA_ST_IDLE) && (st_reg != TBA_ST_DONE) &&
                  (st_reg != TBA_ST_LOCKED);

  always_comb begin
    for (int i = 0; i < NUM_BUF; i++) begin
      if (TECH_ASIC == 1'b0) begin
        ram_clk_en[i] = user_wr[i] ||
          (arb_rd && vidx_reg == TBA_BUF_W'(i)) ||
          (st_reg == TBA_ST_LOCKED && ctl_ptr_upd &&
           used_idx == TBA_BUF_W'(i));
      end else begin
        ram_clk_en[i] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------
  // data word path to the shift register
  // ---------------------------------------------------------
  // word read in the pointer cycle, pushed one cycle later
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= (st_reg == TBA_ST_LOCKED) && ctl_ptr_upd && fifo_ready;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_word_reg <= '0;
    end else if ((st_reg == TBA_ST_LOCKED) && ctl_ptr_upd) begin
      rd_word_reg <= ram_rdata;
    end
  end

  tba_fifo #(.WIDTH(32), .DEPTH(TBA_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(rd_pend_reg),
    .in_ready(fifo_ready),
    .in_data(rd_word_reg),
    .out_valid(data_valid),
    .out_ready(data_ready),
    .out_data(data_word)
  );

  // ---------------------------------------------------------
  // checks
  // ---------------------------------------------------------
  a_lock_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg == TBA_ST_LOCKED && !unlock_cmd && !buf_abort[used_idx])
    |=> (tx_validated || buf_abort[used_idx]))
    else $error("validated dropped while locked");
  a_lock_prio: assert property (@(posedge mclk) disable iff (sys_rst)
    (lock_cmd && tx_validated) |=> st_reg == TBA_ST_LOCKED)
    else $error("lock not taken");
  a_lock_nocap: assert property (@(posedge mclk) disable iff (sys_rst)
    (lock_cmd && tx_validated) |=> $stable(tx_ident) && $stable(tx_meta))
    else $error("capture changed on lock");
  a_abort_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    buf_abort[vbuf_reg] |-> !tx_validated)
    else $error("aborted buffer still validated");
  a_ts_pause: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg == TBA_ST_WAIT_TS && !ts_reached && !lock_cmd && !restart)
    |=> st_reg == TBA_ST_WAIT_TS)
    else $error("validation passed early");
  a_sel_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg inside {TBA_ST_TS_HI, TBA_ST_FFMT, TBA_ST_IDENT} &&
     restart && sel_valid && !(lock_cmd && tx_validated))
    |=> st_reg == TBA_ST_TS_LO)
    else $error("no restart on selection change");
  a_valid_len: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_reg == TBA_ST_WAIT_TS && $past(st_reg) == TBA_ST_TS_HI &&
     ts_reached && !restart && !lock_cmd)
    ##1 (!restart && !lock_cmd)[*2] |-> ##1 vok_reg)
    else $error("validation length wrong");
  a_atomic_cap: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(tx_ident) |-> $past(st_reg) == TBA_ST_IDENT)
    else $error("identifier captured outside step");
  a_gate_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    (TECH_ASIC == 1'b0 && st_reg == TBA_ST_IDLE && user_wr == '0)
    |-> ram_clk_en == '0)
    else $error("ram clock ungated while idle");
  a_locked_addr: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == TBA_ST_LOCKED |-> ram_addr == ctl_addr &&
    ram_idx == used_idx)
    else $error("locked address not from controller");

  c_validate: cover property (@(posedge mclk) disable iff (sys_rst)
    st_reg == TBA_ST_IDENT ##1 vok_reg);
  c_lock: cover property (@(posedge mclk) disable iff (sys_rst)
    lock_cmd && tx_validated);
  c_wait_ts: cover property (@(posedge mclk) disable iff (sys_rst)
    st_reg == TBA_ST_WAIT_TS [*3]);
  c_fifo_full: cover property (@(posedge mclk) disable iff (sys_rst)
    !fifo_ready);
endmodule : tba_arbiter
`default_nettype wire

// ==== tb/tba_ctl_model.sv ====
// frame protocol controller and buffer ram model
`default_nettype none
module tba_ctl_model
  import tba_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic sys_rst, // sync reset, high
  input wire logic tx_validated, // validated buffer exists
  input wire logic req_lock, // bench asks for a lock
  input wire logic req_unlock, // bench asks for an unlock
  input wire logic req_fetch, // bench asks for a data word
  input wire logic suspend, // suspend field was sent
  output logic lock_cmd, // lock pulse
  output logic unlock_cmd, // unlock pulse
  output logic [TBA_ADDR_W-1:0] ctl_addr, // data word address
  output logic ctl_ptr_upd, // read pointer moved
  input wire logic [TBA_BUF_W-1:0] ram_idx, // ram buffer
  input wire logic [TBA_ADDR_W-1:0] ram_addr, // ram word
  output logic [31:0] ram_rdata // ram read data
);
  // ----------------------------------------
  // buffer contents
  // ----------------------------------------
  logic locked_reg;

  function automatic logic [31:0] ram_word(input logic [1:0] b,
                                           input logic [4:0] a);
    case (a)
      TBA_OFS_FFMT: ram_word = {28'hf00_0000, 2'h0, b};
      TBA_OFS_IDENT: ram_word = {28'h1d0_0000, 2'h0, b};
      TBA_OFS_TS_LO: ram_word = (b == 2'h3) ? 32'h0 : {24'h0, b, 6'h10};
      TBA_OFS_TS_HI: ram_word = {31'h0, b == 2'h3};
      default: ram_word = {16'hda7a, 6'h0, b, 3'h0, a};
    endcase
  endfunction : ram_word

  assign ram_rdata = ram_word(ram_idx, ram_addr);

  // ----------------------------------------
  // controller
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lock_cmd <= 1'b0;
      unlock_cmd <= 1'b0;
      ctl_ptr_upd <= 1'b0;
      locked_reg <= 1'b0;
      ctl_addr <= TBA_OFS_DATA0;
    end else begin
      // lock only on a buffer already validated, never after suspend
      lock_cmd <= req_lock && tx_validated && !suspend &&
                  !locked_reg;
      unlock_cmd <= req_unlock && locked_reg;
      if (lock_cmd) begin
        locked_reg <= 1'b1;
      end else if (unlock_cmd) begin
        locked_reg <= 1'b0;
      end
      ctl_ptr_upd <= req_fetch && locked_reg;
      if (lock_cmd) begin
        ctl_addr <= TBA_OFS_DATA0;
      end else if (ctl_ptr_upd) begin
        ctl_addr <= ctl_addr + 5'h01;
      end
    end
  end
endmodule : tba_ctl_model
`default_nettype wire

// ==== tb/tx_buffer_arbitration_tb_top.sv ====
// self-checking testbench for the transmit-buffer arbiter
`default_nettype none
module tx_buffer_arbitration_tb_top
  import tba_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] buf_avail = 4'h0, buf_abort = 4'h0, user_wr = 4'h0;
  logic [11:0] buf_prio = {3'h5, 3'h6, 3'h2, 3'h1};
  logic [63:0] timestamp = 64'h1000;
  logic req_lock = 1'b0, req_unlock = 1'b0, req_fetch = 1'b0;
  logic suspend = 1'b0, data_ready = 1'b0;
  logic [4:0] ram_addr, ctl_addr;
  logic [1:0] ram_idx, used_idx;
  logic [31:0] ram_rdata, tx_meta, tx_ident, data_word;
  logic [3:0] ram_clk_en;
  logic tx_validated, lock_cmd, unlock_cmd, ctl_ptr_upd, retx_clear;
  logic data_valid;
  int err_total = 0;
  int checked = 0;

  always #50 mclk = ~mclk;

  tba_arbiter #(.TECH_ASIC(1'b0)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
    .buf_avail(buf_avail), .buf_prio(buf_prio), .buf_abort(buf_abort),
    .user_wr(user_wr), .timestamp(timestamp), .ram_addr(ram_addr),
    .ram_idx(ram_idx), .ram_rdata(ram_rdata), .ram_clk_en(ram_clk_en),
    .tx_validated(tx_validated), .lock_cmd(lock_cmd),
    .unlock_cmd(unlock_cmd), .ctl_addr(ctl_addr),
    .ctl_ptr_upd(ctl_ptr_upd), .tx_meta(tx_meta), .tx_ident(tx_ident),
    .used_idx(used_idx), .retx_clear(retx_clear),
    .data_valid(data_valid), .data_ready(data_ready),
    .data_word(data_word));

  tba_ctl_model i_ctl (.mclk(mclk), .sys_rst(sys_rst),
    .tx_validated(tx_validated), .req_lock(req_lock),
    .req_unlock(req_unlock), .req_fetch(req_fetch), .suspend(suspend),
    .lock_cmd(lock_cmd), .unlock_cmd(unlock_cmd), .ctl_addr(ctl_addr),
    .ctl_ptr_upd(ctl_ptr_upd), .ram_idx(ram_idx), .ram_addr(ram_addr),
    .ram_rdata(ram_rdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cb(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : cb

  task automatic cw(input string n, input logic [31:0] e,
                    input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cw

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // one-cycle request: 0 lock, 1 fetch, 2 unlock
  task automatic pulse(input int k);
    @(posedge mclk);
    req_lock <= (k == 0);
    req_fetch <= (k == 1);
    req_unlock <= (k == 2);
    @(posedge mclk);
    req_lock <= 1'b0;
    req_fetch <= 1'b0;
    req_unlock <= 1'b0;
  endtask : pulse

  // six cycles from selection to validated, then captures
  task automatic val6(input logic [1:0] b);
    tick(5);
    #1 cb("early", 1'b0, tx_validated);
    cb("clk_run", 1'b1, ram_clk_en[b]);
    @(posedge mclk) #1 cb("validated", 1'b1, tx_validated);
    cw("meta", i_ctl.ram_word(b, 5'h00), tx_meta);
    cw("ident", i_ctl.ram_word(b, 5'h01), tx_ident);
  endtask : val6

  task automatic wait_val(input logic [1:0] b);
    int i;
    for (i = 0; i < 12 && tx_validated !== 1'b1; i++) begin
      @(posedge mclk) #1;
    end
    cb("resumed", 1'b1, tx_validated);
    cw("ident", i_ctl.ram_word(b, 5'h01), tx_ident);
  endtask : wait_val

  task automatic idle(input logic [63:0] ts);
    @(posedge mclk) buf_avail <= 4'h0;
    timestamp <= ts;
    tick(4);
  endtask : idle

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_plain;
    buf_avail <= 4'b0010;
    val6(2'h1);
    cw("clk_gated", 32'h0, {28'h0, ram_clk_en});
    @(posedge mclk) user_wr <= 4'b0100;
    #1 cw("clk_wr", 32'h4, {28'h0, ram_clk_en});
    @(posedge mclk) user_wr <= 4'h0;
  endtask : t_plain

  task automatic t_pause;
    idle(64'h0000_0000_ffff_ffff);
    buf_avail <= 4'b1000;
    tick(20);
    #1 cb("paused", 1'b0, tx_validated);
    @(posedge mclk) timestamp <= 64'h1_0000_0000;
    wait_val(2'h3);
  endtask : t_pause

  task automatic t_prio;
    idle(64'h50);
    buf_avail <= 4'b0101;
    tick(20);
    #1 cb("prio_wait", 1'b0, tx_validated);
    @(posedge mclk) timestamp <= 64'h90;
    wait_val(2'h2);
  endtask : t_prio

  task automatic t_restart;
    idle(64'h1000);
    buf_avail <= 4'b0010;
    tick(3);
    buf_avail <= 4'b0110;
    val6(2'h2);
  endtask : t_restart

  task automatic t_lock;
    int i;
    pulse(0);
    buf_avail <= 4'b1110;
    tick(2);
    #1 cb("held", 1'b1, tx_validated);
    cw("used", 32'h2, {30'h0, used_idx});
    cw("clk_idle", 32'h0, {28'h0, ram_clk_en});
    for (i = 0; i < TBA_FIFO_DEPTH; i++) begin
      pulse(1);
      #1 cb("clk_fetch", 1'b1, ram_clk_en[2]);
      tick(1);
    end
    tick(2);
    #1 cw("ident_kept", i_ctl.ram_word(2'h2, 5'h01), tx_ident);
    @(posedge mclk) data_ready <= 1'b1;
    for (i = 0; i < TBA_FIFO_DEPTH; i++) begin
      #1 cb("dvalid", 1'b1, data_valid);
      cw("data", i_ctl.ram_word(2'h2, 5'(4 + i)), data_word);
      @(posedge mclk);
    end
    #1 cb("drained", 1'b0, data_valid);
    pulse(2);
    tick(2);
  endtask : t_lock

  task automatic t_abort;
    wait_val(2'h2);
    @(posedge mclk) buf_abort <= 4'b0100;
    #1 cb("abort_comb", 1'b0, tx_validated);
    @(posedge mclk) buf_abort <= 4'h0;
    buf_avail <= 4'h0;
    #1 cb("retx_clear", 1'b1, retx_clear);
  endtask : t_abort

  task automatic t_late;
    idle(64'h0);
    buf_avail <= 4'b0010;
    pulse(0);
    timestamp <= 64'h1000;
    wait_val(2'h1);
    tick(2);
    #1 cb("no_tx", 1'b0, i_ctl.locked_reg);
  endtask : t_late

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_plain();
    t_pause();
    t_prio();
    t_restart();
    t_lock();
    t_abort();
    t_late();
    conclude();
  end

  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule : tx_buffer_arbitration_tb_top
`default_nettype wire
